// ### rtl/cfc_pkg.sv
// package for the comparator output filter control block
// assumes a single bus clock domain and a plain register port
package cfc_pkg;
    // register map
    localparam logic [7:0] CTRL_ZERO_OFFSET = 8'h00;
    localparam logic [7:0] CTRL_ZERO_RESET = 8'h00;
    localparam logic [7:0] CTRL_ZERO_WMASK = 8'h73;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // field positions
    localparam int CNT_LSB = 4;
    localparam int CNT_MSB = 6;
    localparam int HYST_LSB = 0;
    localparam int HYST_MSB = 1;
    // filter count codes
    localparam logic [2:0] CNT_OFF = 3'h0;
    localparam logic [2:0] CNT_ONE = 3'h1;
    localparam logic [2:0] CNT_ZERO3 = 3'h0;
    localparam logic [2:0] CNT_STEP = 3'h1;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cfc_bus_req_s;

    // analog side inputs
    typedef struct packed {
        logic raw_windowed_compare_out;
        logic external_sample_mode;
        logic sample_pulse;
    } cfc_analog_in_s;
endpackage

// ### rtl/cfc_sample_filter.sv
// consecutive sample agreement filter
// assumes sample strobes are one bus clock wide and synchronous to clk_in
module cfc_sample_filter (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic sample_in,
    input wire logic data_in,
    input wire logic [2:0] count_in,
    output logic filt_out
);
    logic [2:0] run;
    logic [2:0] next_run;
    logic last;
    logic next_last;
    logic filt;
    logic next_filt;

    // count agreeing samples and accept the new state once enough agree
    always_comb begin
        next_run = run;
        next_last = last;
        next_filt = filt;
        if (sample_in) begin
            next_last = data_in;
            if (data_in == filt) begin
                next_run = cfc_pkg::CNT_ZERO3;
            end else if (data_in != last || run == cfc_pkg::CNT_ZERO3) begin
                next_run = cfc_pkg::CNT_STEP; // first disagreeing sample
            end else begin
                next_run = run + cfc_pkg::CNT_STEP;
            end
            if (data_in != filt && next_run >= count_in) begin
                next_filt = data_in;
                next_run = cfc_pkg::CNT_ZERO3;
            end
        end
    end

    // state registers
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            run <= cfc_pkg::CNT_ZERO3;
            last <= 1'b0;
            filt <= 1'b0;
        end else begin
            run <= next_run;
            last <= next_last;
            filt <= next_filt;
        end
    end

    assign filt_out = filt;
endmodule

// ### rtl/cfc_top.sv
// comparator control register zero with output sample filter
// assumes the analog block's raw output and sample pulse are synchronous to clk_in

// Operation
// - bits 7, 3 and 2 are reserved and always read zero
// - bits 6 to 4 set consecutive agreeing samples needed by the filter
// - count zero bypasses filter; output zero in sample mode, else raw output
// - count one simply samples the comparator output
// - counts two to seven need that many agreeing samples
// - bits 1 to 0 select hysteresis level zero to three
// - sample from external input in sample mode, else divided bus clock
// - filtered result is re-registered in the bus clock, one clock late
module cfc_top (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire cfc_pkg::cfc_bus_req_s bus_in,
    input wire cfc_pkg::cfc_analog_in_s analog_in,
    input wire logic divided_clock_tick_in,
    output logic [7:0] rdata_out,
    output logic [1:0] hysteresis_level_select_out,
    output logic filtered_compare_out
);
    logic [7:0] comparator_control_zero;
    logic [7:0] next_ctrl;
    logic [7:0] next_rdata;
    logic next_out;
    logic [2:0] filter_sample_count;
    logic sample_strobe;
    logic filt;

    assign filter_sample_count = comparator_control_zero[cfc_pkg::CNT_MSB:cfc_pkg::CNT_LSB];
    assign sample_strobe = analog_in.external_sample_mode ? analog_in.sample_pulse
                                                          : divided_clock_tick_in;

    // register write and read data
    always_comb begin
        next_ctrl = comparator_control_zero;
        next_rdata = cfc_pkg::UNMAPPED_READ;
        if (bus_in.wr && bus_in.addr == cfc_pkg::CTRL_ZERO_OFFSET) begin
            next_ctrl = bus_in.wdata & cfc_pkg::CTRL_ZERO_WMASK;
        end
        if (bus_in.rd && bus_in.addr == cfc_pkg::CTRL_ZERO_OFFSET) begin
            next_rdata = comparator_control_zero & cfc_pkg::CTRL_ZERO_WMASK;
        end
    end

    // output select: bypass or filtered
    always_comb begin
        if (filter_sample_count == cfc_pkg::CNT_OFF) begin
            next_out = analog_in.external_sample_mode ? 1'b0
                                                      : analog_in.raw_windowed_compare_out;
        end else begin
            next_out = filt;
        end
    end

    cfc_sample_filter u_filter (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .sample_in(sample_strobe),
        .data_in(analog_in.raw_windowed_compare_out),
        .count_in(filter_sample_count),
        .filt_out(filt)
    );

    // registers
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            comparator_control_zero <= cfc_pkg::CTRL_ZERO_RESET;
            rdata_out <= cfc_pkg::UNMAPPED_READ;
            hysteresis_level_select_out <= 2'h0;
            filtered_compare_out <= 1'b0;
        end else begin
            comparator_control_zero <= next_ctrl;
            rdata_out <= next_rdata;
            hysteresis_level_select_out <= next_ctrl[cfc_pkg::HYST_MSB:cfc_pkg::HYST_LSB];
            filtered_compare_out <= next_out;
        end
    end

    // assertions
    // reserved bits read back as zero
    property p_reserved_zero;
        @(posedge clk_in) disable iff (!arst_n_in)
        $past(bus_in.rd) |-> (rdata_out[7] == 1'b0 && rdata_out[3:2] == 2'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read one");

    // a register write stores the writable fields only
    property p_write_takes;
        @(posedge clk_in) disable iff (!arst_n_in)
        (bus_in.wr && bus_in.addr == cfc_pkg::CTRL_ZERO_OFFSET)
            |=> comparator_control_zero == ($past(bus_in.wdata) & cfc_pkg::CTRL_ZERO_WMASK);
    endproperty
    a_write_takes: assert property (p_write_takes) else $error("write not taken");

    // the hysteresis output takes the written level at the write edge
    property p_hyst;
        @(posedge clk_in) disable iff (!arst_n_in)
        (bus_in.wr && bus_in.addr == cfc_pkg::CTRL_ZERO_OFFSET)
            |=> hysteresis_level_select_out
                == $past(bus_in.wdata[cfc_pkg::HYST_MSB:cfc_pkg::HYST_LSB]);
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis mismatch");

    // bypass in external sample mode drives zero
    property p_bypass_se;
        @(posedge clk_in) disable iff (!arst_n_in)
        (filter_sample_count == cfc_pkg::CNT_OFF && analog_in.external_sample_mode)
            |=> !filtered_compare_out;
    endproperty
    a_bypass_se: assert property (p_bypass_se) else $error("bypass not zero");

    // bypass otherwise passes the raw output one clock later
    property p_bypass_raw;
        @(posedge clk_in) disable iff (!arst_n_in)
        (filter_sample_count == cfc_pkg::CNT_OFF && !analog_in.external_sample_mode)
            |=> filtered_compare_out == $past(analog_in.raw_windowed_compare_out);
    endproperty
    a_bypass_raw: assert property (p_bypass_raw) else $error("bypass not raw");

    // filtered state reaches the output one clock later
    property p_filter_latency;
        @(posedge clk_in) disable iff (!arst_n_in)
        (filter_sample_count != cfc_pkg::CNT_OFF) |=> filtered_compare_out == $past(filt);
    endproperty
    a_filter_latency: assert property (p_filter_latency) else $error("filter latency");

    // count one takes every sample
    property p_one_sample;
        @(posedge clk_in) disable iff (!arst_n_in)
        (filter_sample_count == cfc_pkg::CNT_ONE && sample_strobe)
            |=> filt == $past(analog_in.raw_windowed_compare_out);
    endproperty
    a_one_sample: assert property (p_one_sample) else $error("sampler failed");

    // the filter only moves on a sample strobe
    property p_no_change_without_sample;
        @(posedge clk_in) disable iff (!arst_n_in)
        !sample_strobe |=> $stable(filt);
    endproperty
    a_no_change_without_sample: assert property (p_no_change_without_sample)
        else $error("filter moved without sample");

    // count two never changes on the first differing sample
    property p_two_needed;
        @(posedge clk_in) disable iff (!arst_n_in)
        (filter_sample_count == 3'h2 && sample_strobe
            && analog_in.raw_windowed_compare_out != filt && u_filter.run == 3'h0)
            |=> $stable(filt);
    endproperty
    a_two_needed: assert property (p_two_needed) else $error("changed on first sample");

    // a register read returns both fields
    property p_rdata_fields;
        @(posedge clk_in) disable iff (!arst_n_in)
        (bus_in.rd && bus_in.addr == cfc_pkg::CTRL_ZERO_OFFSET)
            |=> (rdata_out[cfc_pkg::CNT_MSB:cfc_pkg::CNT_LSB] == $past(filter_sample_count)
                && rdata_out[cfc_pkg::HYST_MSB:cfc_pkg::HYST_LSB]
                    == $past(hysteresis_level_select_out));
    endproperty
    a_rdata_fields: assert property (p_rdata_fields) else $error("read data wrong");

    // read data stand one clock and are zero otherwise
    property p_rdata_idle;
        @(posedge clk_in) disable iff (!arst_n_in)
        !bus_in.rd |=> rdata_out == cfc_pkg::UNMAPPED_READ;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

    // reads of other offsets return zero
    property p_unmapped_read;
        @(posedge clk_in) disable iff (!arst_n_in)
        (bus_in.rd && bus_in.addr != cfc_pkg::CTRL_ZERO_OFFSET)
            |=> rdata_out == cfc_pkg::UNMAPPED_READ;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

    // without a register write the control fields hold
    property p_hold_ctrl;
        @(posedge clk_in) disable iff (!arst_n_in)
        !(bus_in.wr && bus_in.addr == cfc_pkg::CTRL_ZERO_OFFSET)
            |=> $stable(comparator_control_zero);
    endproperty
    a_hold_ctrl: assert property (p_hold_ctrl) else $error("control moved without write");

    // the hysteresis level only moves on a register write
    property p_hyst_hold;
        @(posedge clk_in) disable iff (!arst_n_in)
        !(bus_in.wr && bus_in.addr == cfc_pkg::CTRL_ZERO_OFFSET)
            |=> $stable(hysteresis_level_select_out);
    endproperty
    a_hyst_hold: assert property (p_hyst_hold) else $error("hysteresis moved");

    // in external sample mode divided ticks are ignored
    property p_ext_ignores_tick;
        @(posedge clk_in) disable iff (!arst_n_in)
        (analog_in.external_sample_mode && !analog_in.sample_pulse)
            |=> $stable(filt);
    endproperty
    a_ext_ignores_tick: assert property (p_ext_ignores_tick) else $error("tick used");

    // outside external sample mode the sample input is ignored
    property p_int_ignores_pulse;
        @(posedge clk_in) disable iff (!arst_n_in)
        (!analog_in.external_sample_mode && !divided_clock_tick_in)
            |=> $stable(filt);
    endproperty
    a_int_ignores_pulse: assert property (p_int_ignores_pulse) else $error("pulse used");

    // samples equal to the output leave it alone
    property p_agree_holds;
        @(posedge clk_in) disable iff (!arst_n_in)
        (sample_strobe && analog_in.raw_windowed_compare_out == filt)
            |=> $stable(filt);
    endproperty
    a_agree_holds: assert property (p_agree_holds) else $error("moved on equal sample");

    // a run shorter than the count never changes the output
    property p_short_run;
        @(posedge clk_in) disable iff (!arst_n_in)
        (sample_strobe && analog_in.raw_windowed_compare_out != filt
            && u_filter.run + cfc_pkg::CNT_STEP < filter_sample_count)
            |=> $stable(filt);
    endproperty
    a_short_run: assert property (p_short_run) else $error("changed before count");

    // the sample that completes the run changes the output
    property p_flip_on_count;
        @(posedge clk_in) disable iff (!arst_n_in)
        (sample_strobe && analog_in.raw_windowed_compare_out != filt
            && analog_in.raw_windowed_compare_out == u_filter.last
            && u_filter.run + cfc_pkg::CNT_STEP == filter_sample_count)
            |=> filt == $past(analog_in.raw_windowed_compare_out);
    endproperty
    a_flip_on_count: assert property (p_flip_on_count) else $error("no change at count");
endmodule

// ### sim/cfc_analog_model.sv
// stand-in for the analog hard block: raw compare level and sample strobes
// assumes the bench requests levels and strobes just after a rising edge
module cfc_analog_model (
    input wire logic clk_in,
    input wire logic level_in,
    input wire logic ext_mode_in,
    input wire logic strobe_in,
    output cfc_pkg::cfc_analog_in_s analog_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // strobes only reach the filter in external sample mode
    always @(posedge clk_in) begin
        analog_out <= {level_in, ext_mode_in, strobe_in & ext_mode_in};
    end
endmodule

// ### sim/tb.sv
// self-checking bench for the comparator output filter control block
// assumes the analog model on the far side and a 10 MHz clock
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 0, arst_n_in = 0, tick = 0, level = 0, ext = 0, strobe = 0, e = 0;
    cfc_pkg::cfc_bus_req_s bus = '0;
    cfc_pkg::cfc_analog_in_s analog;
    logic [7:0] rdata;
    logic [1:0] hyst;
    logic filt;
    int n_mismatch = 0, n_tests = 0, cycles = 0;
    cfc_analog_model cfc_analog_model_i (.clk_in(clk_in), .level_in(level),
        .ext_mode_in(ext), .strobe_in(strobe), .analog_out(analog));
    cfc_top cfc_top_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus),
        .analog_in(analog), .divided_clock_tick_in(tick), .rdata_out(rdata),
        .hysteresis_level_select_out(hyst), .filtered_compare_out(filt));
    // clock and hang guard
    always #50 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bus cycles, each ends on a rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_in);
        bus <= '0;
        @(posedge clk_in);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk_in);
        bus <= '0;
        @(negedge clk_in);
        chk("rdata", exp, rdata);
        @(posedge clk_in);
    endtask
    // sample strobes with a gap, then three clocks for the output to settle
    task automatic pulse(input int n, input logic use_ext);
        repeat (n) begin
            strobe <= use_ext;
            tick <= ~use_ext;
            @(posedge clk_in);
            strobe <= 1'b0;
            tick <= 1'b0;
            @(posedge clk_in);
        end
        repeat (3) @(posedge clk_in);
    endtask
    task automatic chk_filt(input logic exp);
        @(negedge clk_in);
        chk("filtered", {7'h00, exp}, {7'h00, filt});
        @(posedge clk_in);
    endtask
    task automatic t_regs();
        rd(8'h00, 8'h00);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h73);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 8'h8C | i[7:0]);
            chk("hyst", i[7:0], {6'h00, hyst});
            rd(8'h00, i[7:0]);
        end
        wr(8'h05, 8'h33);
        rd(8'h05, 8'h00);
        rd(8'h00, 8'h03);
        $display("registers done");
    endtask
    task automatic t_bypass();
        wr(8'h00, 8'h00);
        level <= 1'b1;
        pulse(0, 1'b0);
        chk_filt(1'b1);
        level <= 1'b0;
        pulse(0, 1'b0);
        chk_filt(1'b0);
        $display("bypass done");
    endtask
    // each count from one to seven needs exactly that many agreeing samples
    task automatic t_count();
        for (int c = 1; c < 8; c++) begin
            level <= ~e; // the model shows a new level one clock later
            wr(8'h00, {1'b0, c[2:0], 4'h0});
            pulse(c - 1, 1'b0);
            chk_filt(e);
            pulse(1, 1'b0);
            e = ~e;
            chk_filt(e);
        end
        $display("counts done");
    endtask
    // external mode ignores divided ticks; count stays nonzero here
    task automatic t_ext();
        wr(8'h00, 8'h20);
        ext <= 1'b1;
        level <= ~e;
        pulse(4, 1'b0);
        chk_filt(e);
        pulse(2, 1'b1);
        e = ~e;
        chk_filt(e);
        ext <= 1'b0;
        $display("external sample done");
    endtask
    // reset, then scenarios in turn
    initial begin
        repeat (6) @(posedge clk_in);
        arst_n_in <= 1'b1;
        @(posedge clk_in);
        t_regs();
        t_bypass();
        t_count();
        t_ext();
        end_of_test();
    end
endmodule
